// File: slsf_framer.sv
// video framer: sync codes, channel order, line CRC
module slsf_framer #(
    parameter int NCH = 32
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // link word clock
    input wire logic lvds_clk,
    // register port
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    // static configuration
    input wire logic mode_8bit,
    input wire logic mux16,
    input wire logic global_shutter,
    input wire logic crc_seed,
    input wire logic bypass_comp,
    input wire logic [7:0] black_lines,
    input wire logic [11:0] num_lines,
    input wire logic [6:0] line_kernels,
    input wire logic [4:0] win_id,
    // frame request and kernel source
    input wire logic frame_go,
    input wire logic [slsf_pkg::KERNEL_PIX*slsf_pkg::WORD_W-1:0] kernel_data,
    output logic kernel_take,
    output logic line_is_black,
    // serial video words
    output logic [9:0] sync_out,
    output logic [NCH*slsf_pkg::WORD_W-1:0] data_out
);

    localparam int WW = slsf_pkg::WORD_W;
    localparam int KW = slsf_pkg::KERNEL_PIX * WW;

    if (NCH * 2 != slsf_pkg::KERNEL_PIX) begin : g_chk
        $error("slsf_framer: NCH must be half the kernel width");
    end

    // ==========================================================
    // state
    typedef struct packed {
        logic lk_meta;
        logic lk_sync;
        logic lk_prev;
        slsf_pkg::slsf_state_e st;
        logic black;
        logic [11:0] line_cnt;
        logic [11:0] word_cnt;
        logic [6:0] kern_cnt;
        logic [1:0] wk;
        logic [KW-1:0] kernel;
        logic [9:0] offset;
        logic [9:0] r_train;
        logic [9:0] r_marker;
        logic [9:0] r_black;
        logic [9:0] r_image;
        logic [9:0] r_crc;
        logic [9:0] r_trcode;
        logic [15:0] rdata;
        logic [9:0] sync;
        logic [NCH*WW-1:0] data;
        logic take;
    } slsf_state_s;

    slsf_state_s s_q;
    slsf_state_s s_d;

    logic [NCH-1:0][9:0] lane_word;
    logic [NCH-1:0][9:0] lane_crc;
    logic lane_adv;
    logic lane_start;

    // ==========================================================
    // CRC lanes
    for (genvar g = 0; g < NCH; g++) begin : g_lane
        slsf_crc_lane u_lane (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .mode_8bit(mode_8bit),
            .seed_ones(crc_seed),
            .start(lane_start),
            .adv(lane_adv),
            .word(lane_word[g]),
            .crc(lane_crc[g])
        );
    end

    // ==========================================================
    // helpers
    function automatic logic [9:0] fit(input logic m8, input logic [9:0] v);
        return m8 ? {2'b00, v[9:2]} : v;
    endfunction : fit

    function automatic logic [9:0] sync_code(input logic m8, input logic [2:0] t,
                                             input logic [9:0] mk);
        return m8 ? {2'b00, t, mk[6:2]} : {t, mk[6:0]};
    endfunction : sync_code

    // ==========================================================
    // next state
    always_comb begin
        logic strobe;
        logic [1:0] wpk_m1;
        logic [6:0] kern_len;
        logic [11:0] line_words;
        logic [11:0] lines;
        logic [11:0] nblack;
        logic [KW-1:0] kern;
        logic [5:0] p;
        logic [9:0] raw;
        logic [9:0] pix;
        logic [10:0] diff;
        logic [10:0] off_sum;
        logic [9:0] class_tr;
        logic [9:0] data_tr;
        logic [NCH*WW-1:0] train_all;
        logic [9:0] id_word;
        logic [2:0] ls_type;
        logic [2:0] le_type;
        logic last_image;

        s_d = s_q;
        lane_word = '0;
        lane_adv = 1'b0;
        lane_start = 1'b0;
        kern = s_q.kernel;
        p = 6'h00;
        raw = 10'h000;
        pix = 10'h000;
        diff = 11'h000;
        off_sum = 11'h000;

        // link clock synchroniser and rise detect
        s_d.lk_meta = lvds_clk;
        s_d.lk_sync = s_q.lk_meta;
        s_d.lk_prev = s_q.lk_sync;
        strobe = s_q.lk_sync & ~s_q.lk_prev;

        // register port
        if (reg_wr_en) begin
            case (reg_addr)
                slsf_pkg::REG_DATA_TRAIN: s_d.r_train = reg_wdata[9:0];
                slsf_pkg::REG_SYNC_MARKER: s_d.r_marker = reg_wdata[9:0];
                slsf_pkg::REG_BLACK_CODE: s_d.r_black = reg_wdata[9:0];
                slsf_pkg::REG_IMAGE_CODE: s_d.r_image = reg_wdata[9:0];
                slsf_pkg::REG_CRC_CODE: s_d.r_crc = reg_wdata[9:0];
                slsf_pkg::REG_TRAIN_CODE: s_d.r_trcode = reg_wdata[9:0];
                default: ;
            endcase
        end
        if (reg_rd_en) begin
            case (reg_addr)
                slsf_pkg::REG_DATA_TRAIN: s_d.rdata = {6'h00, s_q.r_train};
                slsf_pkg::REG_SYNC_MARKER: s_d.rdata = {6'h00, s_q.r_marker};
                slsf_pkg::REG_BLACK_CODE: s_d.rdata = {6'h00, s_q.r_black};
                slsf_pkg::REG_IMAGE_CODE: s_d.rdata = {6'h00, s_q.r_image};
                slsf_pkg::REG_CRC_CODE: s_d.rdata = {6'h00, s_q.r_crc};
                slsf_pkg::REG_TRAIN_CODE: s_d.rdata = {6'h00, s_q.r_trcode};
                default: s_d.rdata = 16'h0000;
            endcase
        end

        // line geometry
        wpk_m1 = mux16 ? 2'h3 : 2'h1;
        if (s_q.black && global_shutter) begin
            kern_len = slsf_pkg::GS_KERNELS;
        end else if (line_kernels < slsf_pkg::MIN_KERNELS) begin
            kern_len = slsf_pkg::MIN_KERNELS;
        end else begin
            kern_len = line_kernels;
        end
        line_words = mux16 ? {3'h0, kern_len, 2'b00} : {4'h0, kern_len, 1'b0};
        lines = (num_lines == 12'h000) ? 12'h001 : num_lines;
        nblack = {4'h0, (black_lines < slsf_pkg::MIN_BLACK_LINES) ?
                  slsf_pkg::MIN_BLACK_LINES : black_lines};
        last_image = (s_q.line_cnt == lines - 12'h001);

        class_tr = fit(mode_8bit, s_q.r_trcode);
        data_tr = fit(mode_8bit, s_q.r_train);
        train_all = mux16 ? {(NCH / 2){10'h000, data_tr}} : {NCH{data_tr}};
        id_word = mode_8bit ? {3'h0, win_id, 2'b00} : {5'h00, win_id};

        // black lines never use frame codes
        ls_type = (!s_q.black && s_q.line_cnt == 12'h000) ?
                  slsf_pkg::TYPE_FRAME_BEGIN : slsf_pkg::TYPE_LINE_BEGIN;
        le_type = (!s_q.black && last_image) ?
                  slsf_pkg::TYPE_FRAME_FINISH : slsf_pkg::TYPE_LINE_FINISH;

        s_d.take = 1'b0;

        if (strobe) begin
            // one word cycle on all channels
            case (s_q.st)
                slsf_pkg::SLSF_IDLE: begin
                    s_d.sync = class_tr;
                    s_d.data = train_all;
                    if (frame_go) begin
                        s_d.st = slsf_pkg::SLSF_LINE;
                        s_d.black = 1'b1;
                        s_d.line_cnt = 12'h000;
                        s_d.word_cnt = 12'h000;
                        s_d.kern_cnt = 7'h00;
                        s_d.wk = 2'h0;
                    end
                end
                slsf_pkg::SLSF_LINE: begin
                    // sync word
                    if (s_q.word_cnt == 12'h000) begin
                        s_d.sync = sync_code(mode_8bit, ls_type, s_q.r_marker);
                    end else if (s_q.word_cnt == line_words - 12'h002) begin
                        s_d.sync = sync_code(mode_8bit, le_type, s_q.r_marker);
                    end else if (s_q.word_cnt == 12'h001 ||
                                 s_q.word_cnt == line_words - 12'h001) begin
                        s_d.sync = id_word;
                    end else if (s_q.black) begin
                        s_d.sync = fit(mode_8bit, s_q.r_black);
                    end else begin
                        s_d.sync = fit(mode_8bit, s_q.r_image);
                    end

                    // kernel taken on first word
                    if (s_q.wk == 2'h0) begin
                        kern = kernel_data;
                        s_d.kernel = kernel_data;
                        s_d.take = 1'b1;
                    end

                    for (int c = 0; c < NCH; c++) begin
                        if (mux16 && c[0]) begin
                            s_d.data[c*WW +: WW] = 10'h000;
                        end else begin
                            // pixel index
                            if (mux16) begin
                                p = {c[4:1], s_q.wk[0], s_q.wk[1]};
                            end else begin
                                p = {c[4:0], s_q.wk[0]};
                            end
                            if (s_q.kern_cnt[0]) begin
                                p = ~p;
                            end
                            raw = kern[p*WW +: WW];
                            if (s_q.black || bypass_comp) begin
                                pix = raw;
                            end else begin
                                pix = (raw > s_q.offset) ? raw - s_q.offset : 10'h000;
                            end
                            s_d.data[c*WW +: WW] = fit(mode_8bit, pix);
                        end
                        lane_word[c] = s_d.data[c*WW +: WW];
                        if (c == 0 && s_q.black) begin
                            diff = {1'b0, raw} - {1'b0, s_q.offset};
                            off_sum = {1'b0, s_q.offset} +
                                      {{slsf_pkg::OFFSET_SHIFT{diff[10]}},
                                       diff[10:slsf_pkg::OFFSET_SHIFT]};
                            s_d.offset = off_sum[9:0];
                        end
                    end

                    // line words feed the CRC
                    lane_adv = 1'b1;
                    lane_start = (s_q.word_cnt == 12'h000);

                    s_d.wk = (s_q.wk == wpk_m1) ? 2'h0 : s_q.wk + 2'h1;
                    if (s_q.wk == wpk_m1) begin
                        s_d.kern_cnt = s_q.kern_cnt + 7'h01;
                    end
                    s_d.word_cnt = s_q.word_cnt + 12'h001;
                    if (s_q.word_cnt == line_words - 12'h001) begin
                        s_d.st = slsf_pkg::SLSF_CRC;
                    end
                end
                slsf_pkg::SLSF_CRC: begin
                    s_d.sync = fit(mode_8bit, s_q.r_crc);
                    for (int c = 0; c < NCH; c++) begin
                        s_d.data[c*WW +: WW] = (mux16 && c[0]) ? 10'h000 : lane_crc[c];
                    end
                    s_d.st = slsf_pkg::SLSF_GAP;
                    s_d.word_cnt = 12'h000;
                end
                slsf_pkg::SLSF_GAP: begin
                    s_d.sync = class_tr;
                    s_d.data = train_all;
                    s_d.word_cnt = s_q.word_cnt + 12'h001;
                    if (s_q.word_cnt == slsf_pkg::LINE_GAP_WORDS - 12'h001) begin
                        s_d.st = slsf_pkg::SLSF_LINE;
                        s_d.word_cnt = 12'h000;
                        s_d.kern_cnt = 7'h00;
                        s_d.wk = 2'h0;
                        s_d.line_cnt = s_q.line_cnt + 12'h001;
                        if (s_q.black) begin
                            if (s_q.line_cnt + 12'h001 >= nblack) begin
                                s_d.black = 1'b0;
                                s_d.line_cnt = 12'h000;
                            end
                        end else if (last_image) begin
                            s_d.st = slsf_pkg::SLSF_IDLE;
                            s_d.line_cnt = 12'h000;
                        end
                    end
                end
                default: begin
                    s_d.st = slsf_pkg::SLSF_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.st <= slsf_pkg::SLSF_IDLE;
            s_q.r_train <= slsf_pkg::RST_DATA_TRAIN;
            s_q.r_marker <= slsf_pkg::RST_SYNC_MARKER;
            s_q.r_black <= slsf_pkg::RST_BLACK_CODE;
            s_q.r_image <= slsf_pkg::RST_IMAGE_CODE;
            s_q.r_crc <= slsf_pkg::RST_CRC_CODE;
            s_q.r_trcode <= slsf_pkg::RST_TRAIN_CODE;
            s_q.sync <= slsf_pkg::RST_TRAIN_CODE;
            s_q.data <= {NCH{slsf_pkg::RST_DATA_TRAIN}};
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs
    assign reg_rdata = s_q.rdata;
    assign kernel_take = s_q.take;
    assign line_is_black = s_q.black;
    assign sync_out = s_q.sync;
    assign data_out = s_q.data;

endmodule : slsf_framer

// File: slsf_pkg.sv
// shared constants and types of the sync framer
// ==========================================================
package slsf_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] REG_DATA_TRAIN = 8'h82;
    localparam logic [7:0] REG_SYNC_MARKER = 8'h83;
    localparam logic [7:0] REG_BLACK_CODE = 8'h84;
    localparam logic [7:0] REG_IMAGE_CODE = 8'h85;
    localparam logic [7:0] REG_CRC_CODE = 8'h86;
    localparam logic [7:0] REG_TRAIN_CODE = 8'h87;

    localparam logic [9:0] RST_DATA_TRAIN = 10'h3A6;
    localparam logic [9:0] RST_SYNC_MARKER = 10'h02A;
    localparam logic [9:0] RST_BLACK_CODE = 10'h015;
    localparam logic [9:0] RST_IMAGE_CODE = 10'h035;
    localparam logic [9:0] RST_CRC_CODE = 10'h059;
    localparam logic [9:0] RST_TRAIN_CODE = 10'h3A6;

    // ==========================================================
    // sync word type field
    localparam logic [2:0] TYPE_FRAME_BEGIN = 3'h5;
    localparam logic [2:0] TYPE_FRAME_FINISH = 3'h6;
    localparam logic [2:0] TYPE_LINE_BEGIN = 3'h1;
    localparam logic [2:0] TYPE_LINE_FINISH = 3'h2;

    // ==========================================================
    // CRC generators, x^n term implied
    localparam logic [9:0] CRC10_POLY = 10'h24F;
    localparam logic [7:0] CRC8_POLY = 8'h4D;

    // ==========================================================
    // geometry and timing in word cycles
    localparam int WORD_W = 10;
    localparam int KERNEL_PIX = 64;
    localparam logic [6:0] GS_KERNELS = 7'h50;
    localparam logic [6:0] MIN_KERNELS = 7'h02;
    localparam logic [7:0] MIN_BLACK_LINES = 8'h01;
    localparam logic [11:0] LINE_GAP_WORDS = 12'h002;
    localparam int OFFSET_SHIFT = 4;

    typedef enum logic [1:0] {
        SLSF_IDLE,
        SLSF_LINE,
        SLSF_CRC,
        SLSF_GAP
    } slsf_state_e;

endpackage : slsf_pkg

// File: slsf_crc_lane.sv
// per-channel line CRC
module slsf_crc_lane (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // configuration
    input wire logic mode_8bit,
    input wire logic seed_ones,
    // word stream
    input wire logic start,
    input wire logic adv,
    input wire logic [9:0] word,
    // result
    output logic [9:0] crc
);

    typedef struct packed {
        logic [9:0] crc;
    } slsf_lane_s;

    slsf_lane_s s_q;
    slsf_lane_s s_d;

    function automatic logic [9:0] crc_step(input logic m8, input logic [9:0] c_in,
                                            input logic [9:0] d);
        logic [9:0] c;
        logic fb;
        c = c_in;
        fb = 1'b0;
        if (m8) begin
            for (int i = 7; i >= 0; i--) begin
                fb = c[7] ^ d[i];
                c = {2'b00, c[6:0], 1'b0};
                if (fb) begin
                    c[7:0] = c[7:0] ^ slsf_pkg::CRC8_POLY;
                end
            end
        end else begin
            for (int i = 9; i >= 0; i--) begin
                fb = c[9] ^ d[i];
                c = {c[8:0], 1'b0};
                if (fb) begin
                    c = c ^ slsf_pkg::CRC10_POLY;
                end
            end
        end
        return c;
    endfunction : crc_step

    always_comb begin
        logic [9:0] base;
        base = s_q.crc;
        s_d = s_q;
        if (start) begin
            // reseed on first line word
            base = seed_ones ? (mode_8bit ? 10'h0FF : 10'h3FF) : 10'h000;
        end
        if (adv) begin
            s_d.crc = crc_step(mode_8bit, base, word);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign crc = s_q.crc;

endmodule : slsf_crc_lane

// File: slsf_framer_sva.sv
// assertions on the framer ports
module slsf_framer_sva #(
    parameter int NCH = 32
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // configuration
    input wire logic mode_8bit,
    input wire logic mux16,
    input wire logic [4:0] win_id,
    // video side
    input wire logic kernel_take,
    input wire logic line_is_black,
    input wire logic [9:0] sync_out,
    input wire logic [NCH*slsf_pkg::WORD_W-1:0] data_out
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // decoded sync words
    logic in10;
    logic beg10, end10, beg8;
    assign in10 = !mode_8bit;
    assign beg10 = sync_out[9:7] inside {slsf_pkg::TYPE_FRAME_BEGIN, slsf_pkg::TYPE_LINE_BEGIN};
    assign end10 = sync_out[9:7] inside {slsf_pkg::TYPE_FRAME_FINISH, slsf_pkg::TYPE_LINE_FINISH};
    assign beg8 = sync_out[7:5] inside {slsf_pkg::TYPE_FRAME_BEGIN, slsf_pkg::TYPE_LINE_BEGIN};
    // ==========================================================
    // properties
    AST_TAKE_PULSE: assert property (kernel_take |=> !kernel_take)
        else $error("take too long");
    AST_WORD_CYCLE: assert property ($changed(data_out) |=>
        ($stable(sync_out) && $stable(data_out))[*5])
        else $error("words split");
    AST_LINE_ID: assert property (in10 && $changed(sync_out) && beg10 && sync_out[6:0] == 7'h2A
        |-> ##[6:9] sync_out == {5'h00, win_id})
        else $error("no id after begin");
    AST_END_THEN_CRC: assert property (in10 && $changed(sync_out) && end10
        && sync_out[6:0] == 7'h2A |-> ##[14:18] sync_out == slsf_pkg::RST_CRC_CODE)
        else $error("no crc tag after end");
    AST_MUX_ODD_ZERO: assert property (mux16 && in10 && sync_out == slsf_pkg::RST_BLACK_CODE
        |-> data_out[19:10] == 10'h000)
        else $error("odd channel active");
    AST_TRAIN_DATA: assert property (in10 && sync_out == slsf_pkg::RST_TRAIN_CODE
        |-> data_out[9:0] == slsf_pkg::RST_DATA_TRAIN)
        else $error("bad training word");
    AST_NARROW_8BIT: assert property (mode_8bit && $changed(sync_out)
        |-> sync_out[9:8] == 2'b00 && data_out[9:8] == 2'b00)
        else $error("high bits in 8-bit");
    AST_ID_8BIT: assert property (mode_8bit && $changed(sync_out) && beg8 && sync_out[4:0] == 5'h0A
        |-> ##[6:9] sync_out == {3'b000, win_id, 2'b00})
        else $error("bad 8-bit window id");
    AST_BLACK_FLAG: assert property (in10 && sync_out == slsf_pkg::RST_BLACK_CODE
        |-> line_is_black)
        else $error("black tag outside black line");
    cover property (in10 && sync_out == slsf_pkg::RST_CRC_CODE);
    cover property (mux16 && sync_out == slsf_pkg::RST_BLACK_CODE);
    cover property (mode_8bit && kernel_take);
endmodule : slsf_framer_sva

bind slsf_framer slsf_framer_sva #(.NCH(NCH)) slsf_framer_sva_inst (
    .core_clk(core_clk), .rst_n(rst_n), .mode_8bit(mode_8bit), .mux16(mux16),
    .win_id(win_id), .kernel_take(kernel_take), .line_is_black(line_is_black),
    .sync_out(sync_out), .data_out(data_out)
);

// File: slsf_rx_model.sv
// receiver-side model: link word clock and word capture
module slsf_rx_model (
    // link clock
    output logic lvds_clk,
    // captured channels
    input wire logic [9:0] sync_out,
    input wire logic [9:0] data_ch0,
    input wire logic [9:0] data_ch1
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [9:0] sync_q[$];
    logic [9:0] d0_q[$];
    logic [9:0] d1_q[$];
    initial begin
        lvds_clk = 1'b0;
        #17;
        forever #200 lvds_clk = ~lvds_clk;
    end
    // window ids kept raw
    always @(posedge lvds_clk) begin
        sync_q.push_back(sync_out);
        d0_q.push_back(data_ch0);
        d1_q.push_back(data_ch1);
    end
endmodule : slsf_rx_model

// File: slsf_framer_tb.sv
// self-checking bench for the sync framer
module slsf_framer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // signals
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic lvds_clk;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic m8 = 1'b0, mx = 1'b0, gs = 1'b0, seed = 1'b0, byp = 1'b1, go = 1'b0;
    logic [7:0] nblk = 8'h01;
    logic [11:0] nimg = 12'h001;
    logic [6:0] nk = 7'h02;
    logic [4:0] wid = 5'h05;
    logic [9:0] img_code = 10'h035;
    logic [639:0] kdata;
    logic take, blk_flag;
    logic [9:0] sync_out;
    logic [319:0] data_out;
    logic [9:0] exp_s[$], exp_d0[$], exp_d1[$];
    int failures = 0, checked = 0, cycles = 0;
    always #25 core_clk = ~core_clk;
    for (genvar i = 0; i < 64; i++) begin : g_pix
        assign kdata[i*10+:10] = 10'h100 + 10'(i);
    end
    slsf_framer slsf_framer_inst (.core_clk(core_clk), .rst_n(rst_n), .lvds_clk(lvds_clk),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mode_8bit(m8), .mux16(mx),
        .global_shutter(gs), .crc_seed(seed), .bypass_comp(byp), .black_lines(nblk),
        .num_lines(nimg), .line_kernels(nk), .win_id(wid), .frame_go(go),
        .kernel_data(kdata), .kernel_take(take), .line_is_black(blk_flag),
        .sync_out(sync_out), .data_out(data_out));
    slsf_rx_model slsf_rx_model_inst (.lvds_clk(lvds_clk), .sync_out(sync_out),
        .data_ch0(data_out[9:0]), .data_ch1(data_out[19:10]));
    // ==========================================================
    // checks and tasks
    task automatic chk_word(input logic [9:0] got, input logic [9:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected word %0t got %h want %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected reg %0t got %h want %h", $time, got, exp);
        end
    endtask : chk_reg
    task automatic tally_and_finish();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic restart();
        @(posedge core_clk) #5 rst_n = 1'b0;
        repeat (6) @(posedge core_clk);
        #5 rst_n = 1'b1;
    endtask : restart
    task automatic reg_wr(input logic [7:0] a, input logic [9:0] v);
        @(posedge core_clk) #5 reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = {6'h00, v};
        @(posedge core_clk) #5 reg_wr_en = 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge core_clk) #5 reg_rd_en = 1'b1;
        reg_addr = a;
        @(posedge core_clk) #5 reg_rd_en = 1'b0;
        v = reg_rdata;
    endtask : reg_rd
    // ==========================================================
    // expected stream
    function automatic logic [9:0] nar(input logic [9:0] v);
        return m8 ? {2'b00, v[9:2]} : v;
    endfunction : nar
    function automatic logic [9:0] fc(input logic [2:0] t);
        return m8 ? {2'b00, t, 5'h0A} : {t, 7'h2A};
    endfunction : fc
    function automatic logic [9:0] pix(input int c, input int k, input int s);
        int p;
        if (mx && c == 1) return 10'h000;
        p = mx ? 2 * s[0] + s[1] : 2 * c + s;
        if (k % 2 == 1) p = 63 - p;
        return nar(10'h100 + 10'(p));
    endfunction : pix
    function automatic logic [9:0] crc(input logic [9:0] c, input logic [9:0] w);
        logic fb;
        int top;
        top = m8 ? 7 : 9;
        for (int b = top; b >= 0; b--) begin
            fb = w[b] ^ c[top];
            c = {c[8:0], 1'b0} ^ (fb ? (m8 ? 10'h04D : 10'h24F) : 10'h000);
        end
        return m8 ? {2'b00, c[7:0]} : c;
    endfunction : crc
    task automatic tr();
        exp_s.push_back(nar(slsf_pkg::RST_TRAIN_CODE));
        exp_d0.push_back(nar(slsf_pkg::RST_DATA_TRAIN));
        exp_d1.push_back(mx ? 10'h000 : nar(slsf_pkg::RST_DATA_TRAIN));
    endtask : tr
    task automatic line(input logic [2:0] tb_, input logic [2:0] te, input logic [9:0] cls,
                        input int kn);
        int per, len;
        logic [9:0] c0, c1, s;
        per = mx ? 4 : 2;
        len = kn * per;
        c0 = seed ? 10'h3FF : 10'h000;
        c1 = c0;
        for (int w = 0; w < len; w++) begin
            s = (w == 1 || w == len - 1) ? (m8 ? {3'b000, wid, 2'b00} : {5'h00, wid}) : nar(cls);
            s = (w == 0) ? fc(tb_) : (w == len - 2) ? fc(te) : s;
            exp_s.push_back(s);
            exp_d0.push_back(pix(0, w / per, w % per));
            exp_d1.push_back(pix(1, w / per, w % per));
            c0 = crc(c0, exp_d0[$]);
            c1 = crc(c1, exp_d1[$]);
        end
        exp_s.push_back(nar(slsf_pkg::RST_CRC_CODE));
        exp_d0.push_back(c0);
        exp_d1.push_back(mx ? 10'h000 : c1);
        repeat (2) tr();
    endtask : line
    task automatic run_frame();
        int i0, n;
        exp_s.delete();
        exp_d0.delete();
        exp_d1.delete();
        for (int b = 0; b < (nblk == 0 ? 1 : nblk); b++) begin
            line(slsf_pkg::TYPE_LINE_BEGIN, slsf_pkg::TYPE_LINE_FINISH, slsf_pkg::RST_BLACK_CODE,
                 gs ? 80 : nk);
        end
        for (int l = 0; l < nimg; l++) begin
            line(l == 0 ? slsf_pkg::TYPE_FRAME_BEGIN : slsf_pkg::TYPE_LINE_BEGIN,
                 l == nimg - 1 ? slsf_pkg::TYPE_FRAME_FINISH : slsf_pkg::TYPE_LINE_FINISH,
                 img_code, nk);
        end
        repeat (2) tr();
        i0 = slsf_rx_model_inst.sync_q.size();
        @(posedge core_clk) #5 go = 1'b1;
        for (n = 0; blk_flag !== 1'b1 && n < 200; n++) @(posedge core_clk);
        #5 go = 1'b0;
        for (n = 0; n < 20000 && slsf_rx_model_inst.sync_q.size() < i0 + exp_s.size() + 8;
             n++) begin
            @(posedge core_clk);
        end
        for (n = i0 + 8; i0 < n && slsf_rx_model_inst.sync_q[i0] === exp_s[$]; i0++);
        foreach (exp_s[k]) begin
            chk_word(slsf_rx_model_inst.sync_q[i0 + k], exp_s[k]);
            chk_word(slsf_rx_model_inst.d0_q[i0 + k], exp_d0[k]);
            chk_word(slsf_rx_model_inst.d1_q[i0 + k], exp_d1[k]);
        end
    endtask : run_frame
    // ==========================================================
    // scenarios
    task automatic t_regs();
        logic [15:0] v;
        logic [7:0] a[5] = '{8'h82, 8'h84, 8'h85, 8'h86, 8'h87};
        logic [15:0] e[5] = '{16'h03A6, 16'h0015, 16'h0035, 16'h0059, 16'h03A6};
        foreach (a[i]) begin
            reg_rd(a[i], v);
            chk_reg(v, e[i]);
        end
        reg_wr(8'h90, 10'h155);
        reg_rd(8'h90, v);
        chk_reg(v, 16'h0000);
    endtask : t_regs
    task automatic t_mux_global();
        #5 mx = 1'b1;
        gs = 1'b1;
        seed = 1'b1;
        nblk = 8'h00;
        nimg = 12'h002;
        nk = 7'h03;
        restart();
        run_frame();
    endtask : t_mux_global
    task automatic t_frame8();
        logic [15:0] v;
        #5 m8 = 1'b1;
        mx = 1'b0;
        gs = 1'b0;
        nblk = 8'h02;
        nimg = 12'h001;
        restart();
        img_code = 10'h2C4;
        reg_wr(8'h85, img_code);
        reg_rd(8'h85, v);
        chk_reg(v, 16'h02C4);
        run_frame();
    endtask : t_frame8
    initial begin
        restart();
        t_regs();
        run_frame();
        t_mux_global();
        t_frame8();
        tally_and_finish();
    end
endmodule : slsf_framer_tb
